// ==== hdl/led_bar_pkg.sv ====
// Shared constants and types for the charge bar display block
// Operation
// - A falling edge on display_request_n starts a display cycle.
// - Further falling edges are ignored until the display timer expires.
// - Display request is ignored while charging and battery not full.
// - Reference select picks relative or absolute charge percent for scaling.
// - Whole display blinks while remaining capacity is below the alarm level.
// - Display is off while end_of_discharge_flag is set; default all off.
// - Discharging mode applies when not charging or battery removed.
// - Discharging activation lights segments one by one, step delay default 50 ms.
// - After all lit, hold for hold time, then all off together.
// - Below 10 percent the first segment flashes, on and off flash time; the code flashes it from 1 to 10 percent and shows nothing at 0.
// - Discharging segment count follows charge percent by the thresholds table.
// - Charging mode while charging and not full; full shows all off.
// - Charging start sequences segments on, then blinks progress segment, 750 ms.
// - Charging blink segment and lower lit segments follow the charging table.
package led_bar_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET     = 8'h00;
  localparam logic [7:0] STEP_OFFSET     = 8'h04;
  localparam logic [7:0] HOLD_OFFSET     = 8'h08;
  localparam logic [7:0] FLASH_OFFSET    = 8'h0c;
  localparam logic [7:0] BLINK_OFFSET    = 8'h10;
  localparam logic [7:0] GAUGE_OFFSET    = 8'h14;
  localparam logic [7:0] STATUS_OFFSET   = 8'h18;

  // Control field positions
  localparam int CTRL_REF_BIT       = 0;
  localparam int CTRL_IN_SYS_BIT    = 1;
  localparam int CTRL_CHARGING_BIT  = 2;
  localparam int CTRL_FULL_BIT      = 3;
  localparam int CTRL_EOD_BIT       = 4;
  localparam int CTRL_LOW_CAP_BIT   = 5;

  // Gauge field positions: relative percent [7:0], absolute percent [15:8]
  localparam int GAUGE_REL_LSB = 0;
  localparam int GAUGE_ABS_LSB = 8;

  // Times are counted in milliseconds of the time base
  localparam int unsigned CLOCK_HZ   = 125_000_000;
  localparam int unsigned TICK_MS    = 1;
  localparam int unsigned TICK_COUNT = CLOCK_HZ / 1000 * TICK_MS;

  // Reset values, in ms
  localparam logic [15:0] STEP_RESET  = 16'h0032;  // 50 ms
  localparam logic [15:0] HOLD_RESET  = 16'h0bb8;  // 3000 ms
  localparam logic [15:0] FLASH_RESET = 16'h0032;  // 50 ms
  localparam logic [15:0] BLINK_RESET = 16'h02ee;  // 750 ms
  localparam logic [7:0]  CTRL_RESET  = 8'h00;

  // Charge percent thresholds
  localparam logic [7:0] PCT_10 = 8'h0a;
  localparam logic [7:0] PCT_30 = 8'h1e;
  localparam logic [7:0] PCT_50 = 8'h32;
  localparam logic [7:0] PCT_70 = 8'h46;
  localparam logic [7:0] PCT_88 = 8'h58;

  localparam int SEG_COUNT = 5;

  // Battery condition bundle
  typedef struct packed {
    logic in_system;
    logic charging;
    logic full;
    logic end_of_discharge;
    logic low_capacity;
  } battery_state_type;

  // Segment pattern: steady lit segments and the blinking one
  typedef struct packed {
    logic [SEG_COUNT-1:0] lit;
    logic [SEG_COUNT-1:0] blink;
    logic [2:0]           count;
  } seg_pattern_type;

  typedef enum logic [2:0] {
    IDLE_STATE  = 3'b000,
    STEP_STATE  = 3'b001,
    HOLD_STATE  = 3'b010,
    CHG_SEQ     = 3'b011,
    CHG_BLINK   = 3'b100
  } display_request_n_state_type;

endpackage

// ==== hdl/ms_tick.sv ====
// Millisecond time base enable divider
module ms_tick
  import led_bar_pkg::*;
#(
  parameter int unsigned DIVIDE = TICK_COUNT
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // One-cycle pulse per time base period
  output logic      tick
);
  logic [31:0] count_reg;

  // Free running divider, no phase alignment to activation needed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= 32'h0;
      tick      <= 1'b0;
    end else begin
      tick      <= (count_reg == DIVIDE - 1);
      count_reg <= (count_reg == DIVIDE - 1) ? 32'h0 : count_reg + 32'h1;
    end
  end
endmodule

// ==== hdl/seg_decode.sv ====
// Charge percent to segment pattern decoder
module seg_decode
  import led_bar_pkg::*;
(
  // Selected charge percent and mode
  input  wire logic [7:0]      percent,
  input  wire logic            charge_mode,
  // Resulting pattern
  output seg_pattern_type      pattern
);
  // Range decode
  wire band0  = (percent == 8'h00);
  wire band10 = (percent <= PCT_10);
  wire band30 = (percent <= PCT_30);
  wire band50 = (percent <= PCT_50);
  wire band70 = (percent <= PCT_70);
  wire band88 = (percent <= PCT_88);

  wire [2:0] dis_count = band10 ? 3'd0 : band30 ? 3'd1 : band50 ? 3'd2 :
                         band70 ? 3'd3 : band88 ? 3'd4 : 3'd5;
  wire [4:0] dis_lit   = 5'(({5{1'b1}} << dis_count) ^ 5'h1f);
  wire [4:0] dis_blink = (band10 && !band0) ? 5'h01 : 5'h00;

  // Charging table, third row keeps only the first lower segment lit
  wire [4:0] chg_blink = band30 ? 5'h01 : band50 ? 5'h02 : band70 ? 5'h04 :
                         band88 ? 5'h08 : 5'h10;
  wire [4:0] chg_lit   = band30 ? 5'h00 : band50 ? 5'h01 : band70 ? 5'h01 :
                         band88 ? 5'h07 : 5'h0f;

  assign pattern.lit   = charge_mode ? chg_lit : dis_lit;
  assign pattern.blink = charge_mode ? chg_blink : dis_blink;
  assign pattern.count = charge_mode ? 3'd5 : (dis_blink != 5'h0 ? 3'd1 : dis_count);
endmodule

// ==== hdl/led_charge_bar_display.sv ====
// Five segment charge bar display controller with AXI4-Lite registers
module led_charge_bar_display
  import led_bar_pkg::*;
#(
  parameter int unsigned TICK_DIVIDE = TICK_COUNT
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Push button pin and segment drive
  input  wire logic        display_request_n,
  output logic [4:0]       segment_on
);
  // Registers
  logic [7:0]  ctrl_reg;
  logic [15:0] segment_step_delay;
  logic [15:0] segment_hold_time;
  logic [15:0] low_charge_flash_time;
  logic [15:0] charge_progress_blink_time;
  logic [7:0]  relative_charge_percent;
  logic [7:0]  absolute_charge_percent;

  // Pin synchroniser and edge state
  logic req_meta_reg;
  logic req_sync_reg;
  logic req_prev_reg;

  display_request_n_state_type state_reg;
  logic [15:0]    time_reg;
  logic [15:0]    flash_reg;
  logic [15:0]    blink_reg;
  logic           flash_phase_reg;
  logic           blink_phase_reg;
  logic [2:0]     step_reg;
  logic           charging_prev_reg;
  logic           tick;

  seg_pattern_type pattern;
  battery_state_type batt;

  // Battery state taken from the control register
  assign batt.in_system        = ctrl_reg[CTRL_IN_SYS_BIT];
  assign batt.charging         = ctrl_reg[CTRL_CHARGING_BIT];
  assign batt.full             = ctrl_reg[CTRL_FULL_BIT];
  assign batt.end_of_discharge = ctrl_reg[CTRL_EOD_BIT];
  assign batt.low_capacity     = ctrl_reg[CTRL_LOW_CAP_BIT];

  wire capacity_reference_select = ctrl_reg[CTRL_REF_BIT];
  wire end_of_discharge_flag     = batt.end_of_discharge;
  wire charge_mode = batt.in_system && batt.charging && !batt.full;
  wire discharge_mode = !charge_mode;
  wire [7:0] percent = capacity_reference_select ? absolute_charge_percent
                                                 : relative_charge_percent;
  wire req_fall  = req_prev_reg && !req_sync_reg;
  wire timer_idle = (state_reg == IDLE_STATE);
  wire start_dis = req_fall && timer_idle && discharge_mode
                   && !end_of_discharge_flag;
  wire start_chg = charge_mode && !charging_prev_reg;

  ms_tick #(
    .DIVIDE (TICK_DIVIDE)
  ) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  seg_decode u_decode (
    .percent     (percent),
    .charge_mode (charge_mode),
    .pattern     (pattern)
  );

  // Two flops on the pin before anything reads it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_meta_reg <= 1'b1;
      req_sync_reg <= 1'b1;
      req_prev_reg <= 1'b1;
    end else begin
      req_meta_reg <= display_request_n;
      req_sync_reg <= req_meta_reg;
      req_prev_reg <= req_sync_reg;
    end
  end

  // Display sequencer; time_reg counts time base ticks of the current phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg         <= IDLE_STATE;
      time_reg          <= 16'h0;
      step_reg          <= 3'd0;
      charging_prev_reg <= 1'b0;
    end else begin
      charging_prev_reg <= charge_mode;
      if (end_of_discharge_flag || (charge_mode == 1'b0 &&
          (state_reg == CHG_SEQ || state_reg == CHG_BLINK))) begin
        state_reg <= IDLE_STATE;
      end else if (start_chg) begin
        state_reg <= CHG_SEQ;
        time_reg  <= 16'h0;
        step_reg  <= 3'd0;
      end else begin
        case (state_reg)
          IDLE_STATE: begin
            if (start_dis) begin
              state_reg <= STEP_STATE;
              time_reg  <= 16'h0;
              step_reg  <= 3'd0;
            end
          end
          STEP_STATE, CHG_SEQ: begin
            // Hold starts as soon as the last active segment lights, no extra step
            if (step_reg >= pattern.count) begin
              state_reg <= (state_reg == CHG_SEQ) ? CHG_BLINK : HOLD_STATE;
              time_reg  <= 16'h0;
            end else if (tick) begin
              if (time_reg + 16'h1 >= segment_step_delay) begin
                time_reg <= 16'h0;
                step_reg <= step_reg + 3'd1;
              end else begin
                time_reg <= time_reg + 16'h1;
              end
            end
          end
          HOLD_STATE: begin
            if (tick) begin
              if (time_reg + 16'h1 >= segment_hold_time) begin
                state_reg <= IDLE_STATE;
              end else begin
                time_reg <= time_reg + 16'h1;
              end
            end
          end
          CHG_BLINK: state_reg <= CHG_BLINK;
          default:   state_reg <= IDLE_STATE;
        endcase
      end
    end
  end

  // Flash and blink square waves from the time base
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_reg       <= 16'h0;
      blink_reg       <= 16'h0;
      flash_phase_reg <= 1'b1;
      blink_phase_reg <= 1'b1;
    end else if (tick) begin
      if (flash_reg + 16'h1 >= low_charge_flash_time) begin
        flash_reg       <= 16'h0;
        flash_phase_reg <= !flash_phase_reg;
      end else begin
        flash_reg <= flash_reg + 16'h1;
      end
      if (blink_reg + 16'h1 >= charge_progress_blink_time) begin
        blink_reg       <= 16'h0;
        blink_phase_reg <= !blink_phase_reg;
      end else begin
        blink_reg <= blink_reg + 16'h1;
      end
    end
  end

  // Output selection; blink of the whole bar when capacity is low
  wire [4:0] seq_mask  = 5'(({5{1'b1}} << step_reg) ^ 5'h1f);
  wire [4:0] full_pat  = pattern.lit | pattern.blink;
  wire [4:0] dis_show  = (full_pat & seq_mask & ~pattern.blink)
                         | (pattern.blink & seq_mask & {5{flash_phase_reg}});
  wire [4:0] chg_show  = pattern.lit | (pattern.blink & {5{blink_phase_reg}});
  wire [4:0] seq_show  = (state_reg == CHG_SEQ) ? seq_mask
                         : (state_reg == CHG_BLINK) ? chg_show : dis_show;
  wire       low_gate  = !batt.low_capacity || blink_phase_reg;
  wire [4:0] seg_next  = (timer_idle || end_of_discharge_flag) ? 5'h00
                         : (low_gate ? seq_show : 5'h00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      segment_on <= 5'h00;
    end else begin
      segment_on <= seg_next;
    end
  end

  // AXI4-Lite write: accept address and data in either order
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        aw_have_reg;
  logic        w_have_reg;
  wire do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
  wire wr_hit   = (aw_addr_reg <= STATUS_OFFSET) && (aw_addr_reg[1:0] == 2'b00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg   <= s_axi_awaddr;
        aw_have_reg   <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        w_have_reg   <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_have_reg   <= 1'b0;
        w_have_reg    <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Register writes, low two byte lanes used
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg                   <= CTRL_RESET;
      segment_step_delay         <= STEP_RESET;
      segment_hold_time          <= HOLD_RESET;
      low_charge_flash_time      <= FLASH_RESET;
      charge_progress_blink_time <= BLINK_RESET;
      relative_charge_percent    <= 8'h00;
      absolute_charge_percent    <= 8'h00;
    end else if (do_write) begin
      case (aw_addr_reg)
        CTRL_OFFSET:  if (w_strb_reg[0]) ctrl_reg <= w_data_reg[7:0];
        STEP_OFFSET:  if (&w_strb_reg[1:0]) segment_step_delay <= w_data_reg[15:0];
        HOLD_OFFSET:  if (&w_strb_reg[1:0]) segment_hold_time <= w_data_reg[15:0];
        FLASH_OFFSET: if (&w_strb_reg[1:0]) low_charge_flash_time <= w_data_reg[15:0];
        BLINK_OFFSET: if (&w_strb_reg[1:0]) charge_progress_blink_time <= w_data_reg[15:0];
        GAUGE_OFFSET: begin
          if (w_strb_reg[0]) relative_charge_percent <= w_data_reg[GAUGE_REL_LSB +: 8];
          if (w_strb_reg[1]) absolute_charge_percent <= w_data_reg[GAUGE_ABS_LSB +: 8];
        end
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // Read mux, status shows sequencer state, step and segments
  wire [31:0] status_word = {16'h0, 3'b0, segment_on, 1'b0, step_reg,
                             charge_mode, state_reg};
  logic [31:0] rd_mux;
  always_comb begin
    case (s_axi_araddr)
      CTRL_OFFSET:   rd_mux = {24'h0, ctrl_reg};
      STEP_OFFSET:   rd_mux = {16'h0, segment_step_delay};
      HOLD_OFFSET:   rd_mux = {16'h0, segment_hold_time};
      FLASH_OFFSET:  rd_mux = {16'h0, low_charge_flash_time};
      BLINK_OFFSET:  rd_mux = {16'h0, charge_progress_blink_time};
      GAUGE_OFFSET:  rd_mux = {16'h0, absolute_charge_percent, relative_charge_percent};
      STATUS_OFFSET: rd_mux = status_word;
      default:       rd_mux = 32'h0;
    endcase
  end
  wire rd_hit = (s_axi_araddr <= STATUS_OFFSET) && (s_axi_araddr[1:0] == 2'b00);

  // Read channel: one read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_hit ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// ==== dv/led_charge_bar_display_sva.sv ====
// Port level checker for the charge bar display block
module led_charge_bar_display_sva
  import led_bar_pkg::*;
#(
  parameter int unsigned TICK_DIVIDE = TICK_COUNT
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Segment drive
  input wire logic [4:0]  segment_on
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] aw_q;
  logic       w_eod;
  logic       eod_q;

  // Shadow of the shutdown bit; lags the design, so checks wait a few cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q  <= 8'h00;
      w_eod <= 1'b0;
      eod_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) w_eod <= s_axi_wdata[CTRL_EOD_BIT];
      if (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'b00 && aw_q == CTRL_OFFSET)
        eod_q <= w_eod;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Bus handshakes and timing
  AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  AST_AW_BUSY: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write taken");
  AST_BHOLD: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
    else $error("write answer dropped");
  AST_RESP: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00 || s_axi_bresp == 2'b10)
    else $error("bad write response");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_RHOLD: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
    else $error("read answer dropped");
  // Display suppression
  AST_RESET_OFF: assert property (disable iff (1'b0) !aresetn |=> segment_on == 5'h00)
    else $error("segments lit in reset");
  AST_EOD_DARK: assert property (eod_q && $past(eod_q, 3) |-> segment_on == 5'h00)
    else $error("segments lit while shut down");

  C_SLVERR: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
  C_FULL_BAR: cover property (segment_on == 5'h1f);
  C_EOD: cover property (eod_q && $past(eod_q, 3));
endmodule

// ==== dv/button_model.sv ====
// Push button with pull-up on the display request pin
module button_model #(
  parameter int LOW_CYC = 20
) (
  // Clock and press request
  input  wire logic aclk,
  input  wire logic push,
  // Pin seen by the device
  output logic      display_request_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;

  // Released contact reads high through the pull-up
  assign display_request_n = (cnt == 0);

  // Each press closes, then always lets go before another
  always @(posedge aclk) begin
    if (push && cnt == 0) cnt <= LOW_CYC;
    else if (cnt != 0) cnt <= cnt - 1;
  end
endmodule

// ==== dv/led_charge_bar_display_tb.sv ====
// Self-checking bench for the charge bar display block
module led_charge_bar_display_tb
  import led_bar_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TD = 10;
  // Levels table: exp[28:24], control[23:16], gauge {abs, rel}[15:0]
  localparam logic [31:0] LV [11] = '{32'h0002_0000, 32'h0102_000b, 32'h0102_001e,
    32'h0302_5f1f, 32'h0300_0032, 32'h0702_0033, 32'h0f02_0058, 32'h1f00_0059,
    32'h0703_3c5f, 32'h1f01_6400, 32'h0702_0046};
  logic        aclk = 0, aresetn = 0, push = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, pin;
  logic [1:0]  bresp, rresp;
  logic [4:0]  seg, sp = 0;
  logic [4:0]  vq[$];
  int          tq[$];
  int          cyc = 0, mismatches = 0, n_tests = 0;

  led_charge_bar_display #(.TICK_DIVIDE(TD)) uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .display_request_n(pin), .segment_on(seg));
  button_model btn (.aclk(aclk), .push(push), .display_request_n(pin));

  always #4 aclk = ~aclk;

  // Log of each new bar pattern with its cycle
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (seg !== sp) begin
      sp <= seg;
      vq.push_back(seg);
      tq.push_back(cyc);
    end
  end

  task automatic test_done();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // Write; bready stands from the start, only the watchdog ends a wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    bready <= 1'b0;
    chk(bresp, er, "write response");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    rready <= 1'b0;
    chk({rresp, rdata[29:0]}, {er, e[29:0]}, "read");
  endtask

  task automatic press(input int wt);
    vq.delete();
    tq.delete();
    push <= 1'b1;
    @(posedge aclk);
    push <= 1'b0;
    repeat (wt) @(posedge aclk);
  endtask

  task automatic t_regs();
    rd(STEP_OFFSET, {16'h0, STEP_RESET}, 2'b00);
    rd(FLASH_OFFSET, {16'h0, FLASH_RESET}, 2'b00);
    rd(BLINK_OFFSET, {16'h0, BLINK_RESET}, 2'b00);
    rd(CTRL_OFFSET, {24'h0, CTRL_RESET}, 2'b00);
    rd(8'h40, 32'h0, 2'b10);
    wr(8'h40, 32'h5, 2'b10);
    $display("t_regs done");
  endtask

  task automatic t_disch();
    int dt;
    wr(STEP_OFFSET, 32'h2, 2'b00);
    wr(HOLD_OFFSET, 32'h4, 2'b00);
    wr(GAUGE_OFFSET, 32'h5f, 2'b00);
    wr(CTRL_OFFSET, 32'h2, 2'b00);
    press(0);
    for (int i = 0; i < 200 && seg !== 5'h1f; i++) @(posedge aclk);
    push <= 1'b1;
    @(posedge aclk);
    push <= 1'b0;
    repeat (200) @(posedge aclk);
    chk(vq.size(), 6, "pattern count");
    if (vq.size() == 6) begin
      for (int i = 0; i < 6; i++) chk(vq[i], i < 5 ? (1 << (i + 1)) - 1 : 0, "step");
      for (int i = 0; i < 4; i++) begin
        dt = tq[i + 1] - tq[i];
        chk(dt > TD && dt < 3 * TD, 1, "step gap");
      end
      dt = tq[5] - tq[4];
      chk(dt > 3 * TD && dt < 5 * TD, 1, "hold time");
    end
    $display("t_disch done");
  endtask

  task automatic t_levels();
    logic [4:0] acc;
    int n;
    wr(STEP_OFFSET, 32'h1, 2'b00);
    wr(FLASH_OFFSET, 32'h1, 2'b00);
    foreach (LV[k]) begin
      wr(GAUGE_OFFSET, {16'h0, LV[k][15:0]}, 2'b00);
      wr(CTRL_OFFSET, {24'h0, LV[k][23:16]}, 2'b00);
      press(150);
      acc = 5'h00;
      foreach (vq[i]) acc = acc | vq[i];
      chk(acc, LV[k][28:24], "lit pattern");
      chk(seg, 5'h00, "bar off after cycle");
    end
    // Low charge flash of the first segment
    wr(GAUGE_OFFSET, 32'h5, 2'b00);
    press(150);
    n = 0;
    foreach (vq[i]) n += (vq[i] === 5'h01);
    chk(n >= 2 && vq.size() == 2 * n, 1, "low charge flash");
    $display("t_levels done");
  endtask

  task automatic t_eod();
    wr(GAUGE_OFFSET, 32'h5f, 2'b00);
    wr(CTRL_OFFSET, 32'h12, 2'b00);
    press(150);
    chk(vq.size(), 0, "shutdown dark");
    // One tick blink keeps the gate toggling every step, whatever its phase
    wr(BLINK_OFFSET, 32'h1, 2'b00);
    wr(CTRL_OFFSET, 32'h22, 2'b00);
    press(150);
    chk(vq.size() > 6, 1, "low capacity blink");
    wr(CTRL_OFFSET, 32'h2, 2'b00);
    repeat (60) @(posedge aclk);
    $display("t_eod done");
  endtask

  task automatic t_chg(input logic [7:0] pct, input logic [4:0] lo, input logic [4:0] hi);
    int nl;
    int nh;
    wr(GAUGE_OFFSET, {24'h0, pct}, 2'b00);
    vq.delete();
    wr(CTRL_OFFSET, 32'h6, 2'b00);
    repeat (100) @(posedge aclk);
    push <= 1'b1;
    @(posedge aclk);
    push <= 1'b0;
    repeat (100) @(posedge aclk);
    nl = 0;
    nh = 0;
    for (int i = 0; i < 5; i++) chk(vq[i], (1 << (i + 1)) - 1, "charge sequence");
    for (int i = 5; i < vq.size(); i++) begin
      nl += (vq[i] === lo);
      nh += (vq[i] === hi);
    end
    chk(nl > 0 && nh > 0 && nl + nh == vq.size() - 5, 1, "charge blink");
    wr(CTRL_OFFSET, 32'he, 2'b00);
    repeat (30) @(posedge aclk);
    chk(seg, 5'h00, "full bar off");
    wr(CTRL_OFFSET, 32'h2, 2'b00);
    $display("t_chg done");
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_disch();
    t_levels();
    t_eod();
    t_chg(8'h14, 5'h00, 5'h01);
    t_chg(8'h28, 5'h01, 5'h03);
    t_chg(8'h3c, 5'h01, 5'h05);
    t_chg(8'h5f, 5'h0f, 5'h1f);
    test_done();
  end

  // Watchdog well past the expected run length
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    test_done();
  end
endmodule

bind led_charge_bar_display led_charge_bar_display_sva #(.TICK_DIVIDE(TICK_DIVIDE)) chk_i (.*);
